// [design/mmd_pkg.sv]
package mmd_pkg;
    // Program space
    localparam logic [15:0] MMD_FLASH_BASE = 16'h0000;
    localparam logic [15:0] MMD_FLASH_END_LARGE = 16'h3bff;
    localparam logic [15:0] MMD_FLASH_END_SMALL = 16'h1fff;
    // Internal data space
    localparam int MMD_IRAM_BYTES = 256;
    localparam logic [7:0] MMD_LOWER_TOP = 8'h7f;
    localparam logic [7:0] MMD_BITAREA_BASE = 8'h20;
    localparam int MMD_PSW_BANK_LO_POS = 3;
    localparam int MMD_PSW_BANK_HI_POS = 4;
    localparam logic [7:0] MMD_SP_RESET = 8'h07;
    localparam logic [7:0] MMD_PSW_RESET = 8'h00;
    // Special function register addresses handled here
    localparam logic [7:0] MMD_SFR_SP = 8'h81;
    localparam logic [7:0] MMD_SFR_DPL = 8'h82;
    localparam logic [7:0] MMD_SFR_DPH = 8'h83;
    localparam logic [7:0] MMD_SFR_PAGE = 8'haa;
    localparam logic [7:0] MMD_SFR_PSW = 8'hd0;
    // External space
    localparam int MMD_ONCHIP_EXT_RAM_BYTES = 512;
    localparam logic [15:0] MMD_DATA_POINTER16_RESET = 16'h0000;
    localparam logic MMD_PAGE_RESET = 1'b0;

    // Operation codes from the core
    typedef enum logic [2:0] {
        MMD_OP_NONE = 3'b000,
        MMD_OP_DIRECT = 3'b001,
        MMD_OP_INDIRECT = 3'b010,
        MMD_OP_BIT = 3'b011,
        MMD_OP_PUSH = 3'b100,
        MMD_OP_POP = 3'b101,
        MMD_OP_XDPTR = 3'b110,
        MMD_OP_XPAGE = 3'b111
    } mmd_op_t;
endpackage

// [design/mmd_decoder.sv]
// Operation
// - Flash block 0x0000 to 0x3bff or 0x1fff
// - Last Flash byte is lock; above reserved
// - Code reads only; Flash writes via external move
// - External writes hit RAM unless Flash-write set; reads always hit RAM
// - 256 bytes internal RAM at 0x00-0xff
// - Lower 128 bytes direct and indirect
// - 0x00-0x1f four banks, one active
// - Status word bits 3,4 pick bank
// - Bank code n maps to 8n..8n+7
// - Bit address 8k+n is byte 0x20+k
// - Bit versus byte by operand type
// - Upper 128 indirect only, separate from SFRs
// - Above 0x7f: direct SPECIAL_FUNC_REG, indirect RAM
// - Indirect address from work reg 0 or 1
// - Push writes at pointer+1 then increments
// - Reset stack pointer to 0x07
// - 512 bytes on-chip external RAM
// - Pointer form uses full 16-bit pointer; on-chip RAM decodes only its low 9 bits, Flash writes take all 16
// - Pointer visible as high and low SFRs
// - Indexed form: page high, work reg low
// - Only page bit 0 writable, rest zero
// - External RAM needs no setup, fixed timing
`timescale 1ns/10ps
module mmd_decoder
    import mmd_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Core data request
    input wire logic [2:0] op_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic reg_sel_in,
    input wire logic [7:0] wdata_in,
    input wire logic bit_in,
    input wire logic flash_wr_en_in,
    // Core code request
    input wire logic code_rd_in,
    input wire logic [15:0] code_addr_in,
    // Core data answer
    output logic [7:0] rdata_out,
    output logic sfr_sel_out,
    output logic ready_out,
    // Flash port
    output logic flash_rd_out,
    output logic flash_wr_out,
    output logic [15:0] flash_addr_out,
    output logic [7:0] flash_wdata_out,
    output logic flash_lock_sel_out,
    output logic flash_reserved_out,
    // Visible state
    output logic [7:0] stack_ptr_out,
    output logic [1:0] bank_out
);

    logic [7:0] iram_q [MMD_IRAM_BYTES];
    logic [7:0] onchip_ext_ram_q [MMD_ONCHIP_EXT_RAM_BYTES];
    logic [7:0] stack_ptr_q;
    logic [7:0] psw_q;
    logic [15:0] data_pointer16_q;
    logic onchip_ext_ram_page_bit_q;
    logic [7:0] rdata_q;
    logic sfr_sel_q;
    logic ready_q;
    logic flash_rd_q;
    logic flash_wr_q;
    logic [15:0] flash_addr_q;
    logic [7:0] flash_wdata_q;
    logic flash_lock_q;
    logic flash_resv_q;

    mmd_op_t op;
    logic [1:0] bank;
    logic [7:0] work_reg_addr;
    logic [7:0] ind_addr;
    logic [7:0] bit_byte_addr;
    logic [2:0] bit_pos;
    logic [15:0] xaddr;
    logic [8:0] xidx;
    logic [15:0] flash_end;
    logic direct_sfr;
    logic [7:0] sp_inc;
    logic x_to_flash;
    logic x_op;
    logic psw_bit_hit;
    // Write decode shared by the per-entry storage
    logic iram_we;
    logic [7:0] iram_waddr;
    logic [7:0] iram_wbyte;
    logic onchip_ext_ram_we;
    // Flash address chosen before it is registered
    logic [15:0] flash_next_addr;

    assign op = mmd_op_t'(op_in);
    assign bank = {psw_q[MMD_PSW_BANK_HI_POS], psw_q[MMD_PSW_BANK_LO_POS]};
    // Working register 0 or 1 of the active bank
    assign work_reg_addr = {3'b000, bank, 2'b00, reg_sel_in};
    assign ind_addr = iram_q[work_reg_addr];
    assign bit_byte_addr = MMD_BITAREA_BASE + {4'h0, addr_in[6:3]};
    assign bit_pos = addr_in[2:0];
    assign direct_sfr = addr_in > MMD_LOWER_TOP;
    assign sp_inc = stack_ptr_q + 8'h01;
    assign psw_bit_hit = addr_in[7:3] == MMD_SFR_PSW[7:3];
    assign x_op = (op == MMD_OP_XDPTR) || (op == MMD_OP_XPAGE);
    // Effective external address for the two move forms
    always_comb begin
        xaddr = {7'h00, onchip_ext_ram_page_bit_q, ind_addr};
        if (op == MMD_OP_XDPTR) begin
            xaddr = data_pointer16_q;
        end
    end
    // Upper bits of the 16-bit address are ignored, so the 512 bytes repeat
    assign xidx = xaddr[8:0];
    assign flash_end = LARGE_VARIANT ? MMD_FLASH_END_LARGE : MMD_FLASH_END_SMALL;
    assign x_to_flash = flash_wr_en_in && wr_in && x_op;
    assign onchip_ext_ram_we = wr_in && !x_to_flash && x_op;

    // Internal RAM write decode; a bit write rewrites its whole byte in one cycle
    always_comb begin
        iram_we = 1'b0;
        iram_waddr = addr_in;
        iram_wbyte = wdata_in;
        unique case (op)
            MMD_OP_PUSH: begin
                // Push always writes; the core gives no write flag with it
                iram_we = 1'b1;
                iram_waddr = sp_inc;
            end
            MMD_OP_DIRECT: begin
                iram_we = wr_in && !direct_sfr;
            end
            MMD_OP_INDIRECT: begin
                iram_we = wr_in;
                iram_waddr = ind_addr;
            end
            MMD_OP_BIT: begin
                iram_we = wr_in && !direct_sfr;
                iram_waddr = bit_byte_addr;
                iram_wbyte = iram_q[bit_byte_addr];
                iram_wbyte[bit_pos] = bit_in;
            end
            default: begin
            end
        endcase
    end

    // Internal RAM, one byte register per entry, loaded on an index match
    for (genvar i = 0; i < MMD_IRAM_BYTES; i++) begin : g_iram
        always_ff @(posedge clk_sys_in) begin
            if (iram_we && iram_waddr == 8'(i)) begin
                iram_q[i] <= iram_wbyte;
            end
        end
    end

    // External RAM, one byte register per entry; not reset, like the internal RAM
    for (genvar j = 0; j < MMD_ONCHIP_EXT_RAM_BYTES; j++) begin : g_onchip_ext_ram
        always_ff @(posedge clk_sys_in) begin
            if (onchip_ext_ram_we && xidx == 9'(j)) begin
                onchip_ext_ram_q[j] <= wdata_in;
            end
        end
    end

    // Stack pointer
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stack_ptr_q <= MMD_SP_RESET;
        end else if (op == MMD_OP_PUSH) begin
            stack_ptr_q <= sp_inc;
        end else if (op == MMD_OP_POP) begin
            stack_ptr_q <= stack_ptr_q - 8'h01;
        end else if (op == MMD_OP_DIRECT && wr_in && addr_in == MMD_SFR_SP) begin
            stack_ptr_q <= wdata_in;
        end
    end

    // Status word: byte writes and single-bit writes both land here
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            psw_q <= MMD_PSW_RESET;
        end else if (op == MMD_OP_DIRECT && wr_in && addr_in == MMD_SFR_PSW) begin
            psw_q <= wdata_in;
        end else if (op == MMD_OP_BIT && wr_in && psw_bit_hit) begin
            psw_q[bit_pos] <= bit_in;
        end
    end

    // Data pointer halves and page register as special function registers
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_pointer16_q <= MMD_DATA_POINTER16_RESET;
            onchip_ext_ram_page_bit_q <= MMD_PAGE_RESET;
        end else if (op == MMD_OP_DIRECT && wr_in) begin
            unique case (addr_in)
                MMD_SFR_DPH: begin
                    data_pointer16_q[15:8] <= wdata_in;
                end
                MMD_SFR_DPL: begin
                    data_pointer16_q[7:0] <= wdata_in;
                end
                MMD_SFR_PAGE: begin
                    // Bits 7:1 are dropped, so the page is only ever 0 or 1
                    onchip_ext_ram_page_bit_q <= wdata_in[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Space select follows direct and bit accesses only
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sfr_sel_q <= 1'b0;
        end else begin
            sfr_sel_q <= (op == MMD_OP_DIRECT || op == MMD_OP_BIT) && direct_sfr;
        end
    end

    // Read data holds between requests
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (op)
                MMD_OP_DIRECT: begin
                    if (!direct_sfr) begin
                        rdata_q <= iram_q[addr_in];
                    end else begin
                        unique case (addr_in)
                            MMD_SFR_SP: begin
                                rdata_q <= stack_ptr_q;
                            end
                            MMD_SFR_PSW: begin
                                rdata_q <= psw_q;
                            end
                            MMD_SFR_DPH: begin
                                rdata_q <= data_pointer16_q[15:8];
                            end
                            MMD_SFR_DPL: begin
                                rdata_q <= data_pointer16_q[7:0];
                            end
                            MMD_SFR_PAGE: begin
                                rdata_q <= {7'h00, onchip_ext_ram_page_bit_q};
                            end
                            default: begin
                                // Registers kept elsewhere read as zero here
                                rdata_q <= 8'h00;
                            end
                        endcase
                    end
                end
                MMD_OP_INDIRECT: rdata_q <= iram_q[ind_addr];
                MMD_OP_BIT: begin
                    // Of the registers kept here only the status word is bit addressable
                    if (!direct_sfr) begin
                        rdata_q <= {7'h00, iram_q[bit_byte_addr][bit_pos]};
                    end else if (psw_bit_hit) begin
                        rdata_q <= {7'h00, psw_q[bit_pos]};
                    end else begin
                        rdata_q <= 8'h00;
                    end
                end
                MMD_OP_POP: rdata_q <= iram_q[stack_ptr_q];
                MMD_OP_XDPTR, MMD_OP_XPAGE: rdata_q <= onchip_ext_ram_q[xidx];
                default: rdata_q <= rdata_q;
            endcase
        end
    end

    // Every request answers next cycle; no setup or wait states
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (op != MMD_OP_NONE) || code_rd_in;
        end
    end

    // Flash address this cycle; a redirected write beats a code read
    always_comb begin
        flash_next_addr = code_addr_in;
        if (x_to_flash) begin
            flash_next_addr = xaddr;
        end
    end

    // Flash strobes last one cycle each
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_rd_q <= 1'b0;
            flash_wr_q <= 1'b0;
        end else begin
            flash_rd_q <= code_rd_in;
            flash_wr_q <= x_to_flash;
        end
    end

    // Address holds until the next flash access, write data until the next flash write
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_addr_q <= MMD_FLASH_BASE;
            flash_wdata_q <= 8'h00;
        end else if (x_to_flash || code_rd_in) begin
            flash_addr_q <= flash_next_addr;
            if (x_to_flash) begin
                flash_wdata_q <= wdata_in;
            end
        end
    end

    // Lock byte and reserved range are judged on flash_next_addr and registered with the address
    // so both flags always describe the same access
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flash_lock_q <= 1'b0;
            flash_resv_q <= 1'b0;
        end else if (x_to_flash || code_rd_in) begin
            flash_lock_q <= flash_next_addr == flash_end;
            flash_resv_q <= flash_next_addr > flash_end;
        end
    end

    assign rdata_out = rdata_q;
    assign sfr_sel_out = sfr_sel_q;
    assign ready_out = ready_q;
    assign flash_rd_out = flash_rd_q;
    assign flash_wr_out = flash_wr_q;
    assign flash_addr_out = flash_addr_q;
    assign flash_wdata_out = flash_wdata_q;
    assign flash_lock_sel_out = flash_lock_q;
    assign flash_reserved_out = flash_resv_q;
    assign stack_ptr_out = stack_ptr_q;
    assign bank_out = bank;

endmodule // mmd_decoder

// [tb/mmd_decoder_sva.sv]
`timescale 1ns/10ps
module mmd_decoder_sva
    import mmd_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Requests
    input wire logic [2:0] op_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic flash_wr_en_in,
    input wire logic code_rd_in,
    input wire logic [15:0] code_addr_in,
    // Answers
    input wire logic sfr_sel_out,
    input wire logic ready_out,
    input wire logic flash_rd_out,
    input wire logic flash_wr_out,
    input wire logic [15:0] flash_addr_out,
    input wire logic flash_lock_sel_out,
    input wire logic flash_reserved_out,
    input wire logic [7:0] stack_ptr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    logic [15:0] lock;
    logic xw;
    assign lock = LARGE_VARIANT ? MMD_FLASH_END_LARGE : MMD_FLASH_END_SMALL;
    assign xw = (op_in == MMD_OP_XDPTR || op_in == MMD_OP_XPAGE) && wr_in;
    sequence s_req; op_in != 3'h0 || code_rd_in; endsequence
    sequence s_fwr; xw && flash_wr_en_in; endsequence
    sequence s_cr; code_rd_in && !(xw && flash_wr_en_in); endsequence
    property p_ready; s_req |=> ready_out; endproperty
    property p_idle; !(op_in != 3'h0 || code_rd_in) |=> !ready_out; endproperty
    property p_push; op_in == MMD_OP_PUSH |=> stack_ptr_out == $past(stack_ptr_out) + 8'h01;
    endproperty
    property p_sfr; op_in == MMD_OP_DIRECT |=> sfr_sel_out == $past(addr_in[7]); endproperty
    property p_fwr; s_fwr |=> flash_wr_out; endproperty
    property p_onchip_ext_ram; xw && !flash_wr_en_in |=> !flash_wr_out; endproperty
    property p_code; s_cr |=> flash_rd_out && flash_addr_out == $past(code_addr_in); endproperty
    property p_lock; s_cr |=> flash_lock_sel_out == ($past(code_addr_in) == lock)
        && flash_reserved_out == ($past(code_addr_in) > lock); endproperty
    a_ready: assert property (p_ready) else $error("no ready after request");
    a_idle: assert property (p_idle) else $error("ready without request");
    a_push: assert property (p_push) else $error("push did not step pointer");
    a_sfr: assert property (p_sfr) else $error("space select wrong");
    a_fwr: assert property (p_fwr) else $error("flash write missing");
    a_onchip_ext_ram: assert property (p_onchip_ext_ram) else $error("flash written by default");
    a_code: assert property (p_code) else $error("code read wrong");
    a_lock: assert property (p_lock) else $error("lock or reserved flag wrong");
endmodule // mmd_decoder_sva
bind mmd_decoder mmd_decoder_sva #(.LARGE_VARIANT(LARGE_VARIANT)) i_mmd_decoder_sva (.*);

// [tb/mmd_core_model.sv]
`timescale 1ns/10ps
module mmd_core_model (
    // Clock
    input wire logic clk_sys_in,
    // Request
    output logic [2:0] op_out,
    output logic wr_out,
    output logic [7:0] addr_out,
    output logic sel_out,
    output logic [7:0] wdata_out,
    output logic bit_out,
    output logic cr_out,
    output logic [15:0] ca_out,
    // Answer
    input wire logic [7:0] rdata_in,
    input wire logic ready_in
);
    initial begin
        {op_out, wr_out, addr_out, sel_out, wdata_out, bit_out, cr_out, ca_out} = '0;
    end
    // One request per call; select and code address ride on the address, the bit on write data, to keep calls short
    task automatic req(input logic [2:0] op, input logic wr, input logic [15:0] a,
        input logic [7:0] wd, input logic cr, output logic [7:0] rd, output logic ok);
        int n;
        @(posedge clk_sys_in);
        #1;
        {op_out, wr_out, addr_out, sel_out} = {op, wr, a[7:0], a[0]};
        {wdata_out, bit_out, cr_out, ca_out} = {wd, wd[0], cr, a};
        @(posedge clk_sys_in);
        #1;
        {op_out, cr_out} = '0;
        // Stale address, write data and code address are scrambled so nothing leans on their held values
        {addr_out, wdata_out, ca_out} = ~{addr_out, wdata_out, ca_out};
        for (n = 0; n < 4 && ready_in !== 1'b1; n++) begin
            @(posedge clk_sys_in);
            #1;
        end
        rd = rdata_in;
        ok = n < 4;
    endtask
endmodule // mmd_core_model

// [tb/mmd_decoder_tb.sv]
`timescale 1ns/10ps
module mmd_decoder_tb;
    import mmd_pkg::*;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic flash_wr_en_in = 1'b0;
    logic [2:0] op;
    logic wr, sel, bt, cr, ok, ready, fr, fw, lk, rs, ss;
    logic [7:0] addr, wd, rdq, fwd, sp, rd;
    logic [15:0] ca, fa;
    logic [1:0] bank;
    int errors = 0;
    int checks = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    mmd_decoder i_mmd_decoder (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .op_in(op),
        .wr_in(wr), .addr_in(addr), .reg_sel_in(sel), .wdata_in(wd), .bit_in(bt),
        .flash_wr_en_in(flash_wr_en_in), .code_rd_in(cr), .code_addr_in(ca), .rdata_out(rdq),
        .sfr_sel_out(ss), .ready_out(ready), .flash_rd_out(fr), .flash_wr_out(fw),
        .flash_addr_out(fa), .flash_wdata_out(fwd), .flash_lock_sel_out(lk),
        .flash_reserved_out(rs), .stack_ptr_out(sp), .bank_out(bank));
    mmd_core_model i_mmd_core_model (.clk_sys_in(clk_sys_in), .op_out(op), .wr_out(wr),
        .addr_out(addr), .sel_out(sel), .wdata_out(wd), .bit_out(bt), .cr_out(cr),
        .ca_out(ca), .rdata_in(rdq), .ready_in(ready));
    task test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rq(input logic [2:0] o, input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic c = 1'b0);
        i_mmd_core_model.req(o, w, a, d, c, rd, ok);
        if (!ok) begin
            errors++;
            $display("wrong value ready expected 1 seen 0");
            test_done();
        end
    endtask
    task t_stack;
        chk("stack_ptr", MMD_SP_RESET, sp);
        rq(MMD_OP_PUSH, 1'b1, 16'h0, 8'ha5);
        chk("stack_ptr", 8'h08, sp);
        rq(MMD_OP_DIRECT, 1'b0, 16'h08, 8'h00);
        chk("first push", 8'ha5, rd);
        rq(MMD_OP_POP, 1'b0, 16'h0, 8'h00);
        chk("pop", 8'ha5, rd);
    endtask
    task t_bank;
        rq(MMD_OP_DIRECT, 1'b1, 16'hd0, 8'h18);
        chk("bank", 8'h03, {6'h0, bank});
        rq(MMD_OP_DIRECT, 1'b1, 16'h18, 8'h90);
        rq(MMD_OP_INDIRECT, 1'b1, 16'h0, 8'h5a);
        rq(MMD_OP_DIRECT, 0, 16'h90, 0);
        chk("sfr read", 8'h00, rd);
        chk("sfr_sel", 8'h01, {7'h0, ss});
        rq(MMD_OP_INDIRECT, 1'b0, 16'h0, 8'h00);
        chk("upper ram", 8'h5a, rd);
    endtask
    task t_bit;
        rq(MMD_OP_DIRECT, 1'b1, 16'h22, 8'h00);
        rq(MMD_OP_BIT, 1'b1, 16'h13, 8'h01);
        rq(MMD_OP_DIRECT, 1'b0, 16'h22, 8'h00);
        chk("bit byte", 8'h08, rd);
        rq(MMD_OP_BIT, 1'b0, 16'h13, 8'h00);
        chk("bit read", 8'h01, rd);
    endtask
    task t_onchip_ext_ram;
        rq(MMD_OP_DIRECT, 1'b1, 16'h83, 8'h01);
        rq(MMD_OP_DIRECT, 1'b1, 16'h82, 8'h23);
        rq(MMD_OP_XDPTR, 1'b1, 16'h0, 8'h77);
        rq(MMD_OP_DIRECT, 1'b1, 16'haa, 8'hff);
        rq(MMD_OP_DIRECT, 1'b0, 16'haa, 8'h00);
        chk("page", 8'h01, rd);
        rq(MMD_OP_DIRECT, 1'b1, 16'h18, 8'h23);
        rq(MMD_OP_XPAGE, 1'b0, 16'h0, 8'h00);
        chk("paged read", 8'h77, rd);
        rq(MMD_OP_DIRECT, 1'b1, 16'h83, 8'h03);
        rq(MMD_OP_XDPTR, 1'b0, 16'h0, 8'h00);
        chk("alias read", 8'h77, rd);
        rq(MMD_OP_DIRECT, 1'b0, 16'h83, 8'h00);
        chk("pointer high", 8'h03, rd);
    endtask
    task t_flash;
        rq(MMD_OP_NONE, 1'b0, 16'h3bff, 8'h00, 1'b1);
        chk("lock_sel", 8'h01, {7'h0, lk});
        rq(MMD_OP_NONE, 1'b0, 16'h3c00, 8'h00, 1'b1);
        chk("reserved", 8'h01, {7'h0, rs});
        flash_wr_en_in = 1'b1;
        rq(MMD_OP_XDPTR, 1'b1, 16'h0, 8'h3c);
        flash_wr_en_in = 1'b0;
        chk("flash_wdata", 8'h3c, fwd);
        chk("flash_addr", 8'h03, fa[15:8]);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_in);
        #1;
        arst_n_in = 1'b1;
        t_stack();
        t_bank();
        t_bit();
        t_onchip_ext_ram();
        t_flash();
        test_done();
    end
endmodule // mmd_decoder_tb
